// >>> shared/tcsp_defs.svh
`ifndef TCSP_DEFS_SVH
`define TCSP_DEFS_SVH

// Output levels for the cable-mated and orientation outputs.
`define TCSP_MATED_NONE 1'h0
`define TCSP_MATED_BOTH 1'h1
`define TCSP_ORIENT_CC1 1'h0
`define TCSP_ORIENT_CC2 1'h1

// Reset values of the status outputs.
`define TCSP_RST_MATED 1'h0
`define TCSP_RST_ORIENT 1'h0
`define TCSP_RST_ALARM_N 1'h1
`define TCSP_RST_IRQ_N 1'h1

// Filter time for the analog detector levels, in nanoseconds.
`define TCSP_FILTER_NS 32
`define TCSP_CLK_NS 8
`define TCSP_FILTER_CYC ((`TCSP_FILTER_NS + `TCSP_CLK_NS - 1) / `TCSP_CLK_NS)

`endif

// >>> shared/tcsp_pkg.sv
package tcsp_pkg;

    typedef enum logic [1:0]
    {
        TCSP_MODE_OFF,
        TCSP_MODE_SOURCE,
        TCSP_MODE_SINK
    } tcsp_mode_t;

    typedef enum
    {
        TCSP_ST_DETACHED,
        TCSP_ST_ATTACHED
    } tcsp_state_t;

endpackage

// >>> core/tcsp_filter.sv
`timescale 1ns/1ns
`include "tcsp_defs.svh"

// Holds a level until the input has been steady for a number of cycles.
module tcsp_filter
#(
    parameter int CYCLES = `TCSP_FILTER_CYC
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic stable
);

    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
        end
        else if (raw == stable)
        begin
            count <= '0;
        end
        else
        begin
            count <= count + CW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stable <= 1'b0;
        end
        else if (raw != stable && count >= CW'(CYCLES - 1))
        begin
            stable <= raw;
        end
    end

endmodule

// >>> core/tcsp_status.sv
`timescale 1ns/1ns
`include "tcsp_defs.svh"

module tcsp_status
#(
    parameter int FILTER_CYC = `TCSP_FILTER_CYC
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire tcsp_pkg::tcsp_mode_t mode,
    input wire logic cc1_rd_seen,
    input wire logic cc2_rd_seen,
    input wire logic cc1_rp_seen,
    input wire logic cc2_rp_seen,
    input wire logic cc1_above_cc2,
    input wire logic overcurrent_sensed,
    input wire logic port_power_switch_on,
    input wire logic irq_clear,
    output logic cable_mated,
    output logic orientation,
    output logic overcurrent_alarm_n,
    output logic power_switch_irq_source,
    output logic vbus_switch_enable,
    output logic irq_n
);

    logic [4:0] raw;
    logic [4:0] filt;
    tcsp_pkg::tcsp_state_t state;
    logic src_mode;
    logic snk_mode;
    logic src_attach;
    logic snk_attach;
    logic attach_now;
    logic next_orient;
    logic irq_pending;

    assign raw = {cc1_rd_seen, cc2_rd_seen, cc1_rp_seen, cc2_rp_seen,
        cc1_above_cc2};

    for (genvar i = 0; i < 5; i++)
    begin : g_filt
        tcsp_filter #(.CYCLES(FILTER_CYC)) u_filt
        (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .raw(raw[i]),
            .stable(filt[i])
        );
    end

    assign src_mode = (mode == tcsp_pkg::TCSP_MODE_SOURCE);
    assign snk_mode = (mode == tcsp_pkg::TCSP_MODE_SINK);
    // Exactly one Rd seen means a sink sits at the far end.
    assign src_attach = src_mode && (filt[4] ^ filt[3]);
    assign snk_attach = snk_mode && (filt[2] | filt[1]);
    assign attach_now = src_attach || snk_attach;

    always_comb
    begin
        if (src_mode)
        begin
            next_orient = filt[4] ? `TCSP_ORIENT_CC1 : `TCSP_ORIENT_CC2;
        end
        else
        begin
            next_orient = filt[0] ? `TCSP_ORIENT_CC1 : `TCSP_ORIENT_CC2;
        end
    end

    // Attach tracking runs on its own, no host command involved.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= tcsp_pkg::TCSP_ST_DETACHED;
        end
        else
        begin
            case (state)
                tcsp_pkg::TCSP_ST_DETACHED:
                begin
                    if (attach_now)
                    begin
                        state <= tcsp_pkg::TCSP_ST_ATTACHED;
                    end
                end
                tcsp_pkg::TCSP_ST_ATTACHED:
                begin
                    if (!attach_now)
                    begin
                        state <= tcsp_pkg::TCSP_ST_DETACHED;
                    end
                end
                default:
                begin
                    state <= tcsp_pkg::TCSP_ST_DETACHED;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cable_mated <= `TCSP_RST_MATED;
        end
        else
        begin
            cable_mated <= attach_now ? `TCSP_MATED_BOTH
                : `TCSP_MATED_NONE;
        end
    end

    // Orientation is latched on attach and held while attached.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            orientation <= `TCSP_RST_ORIENT;
        end
        else if (!attach_now)
        begin
            orientation <= `TCSP_RST_ORIENT;
        end
        else if (state == tcsp_pkg::TCSP_ST_DETACHED)
        begin
            orientation <= next_orient;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overcurrent_alarm_n <= `TCSP_RST_ALARM_N;
        end
        else
        begin
            overcurrent_alarm_n <= !(src_mode && overcurrent_sensed);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_switch_irq_source <= 1'b0;
        end
        else
        begin
            power_switch_irq_source <= src_mode && overcurrent_sensed;
        end
    end

    // Power is cut on the next clock edge after over-current is sensed.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vbus_switch_enable <= 1'b0;
        end
        else
        begin
            vbus_switch_enable <= src_mode && port_power_switch_on
                && !overcurrent_sensed;
        end
    end

    // Sticky pending flag; a new event wins over a clear.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_pending <= 1'b0;
        end
        else if (src_mode && overcurrent_sensed)
        begin
            irq_pending <= 1'b1;
        end
        else if (irq_clear)
        begin
            irq_pending <= 1'b0;
        end
    end

    assign irq_n = !irq_pending;

endmodule

// >>> dv/tcsp_status_checker.sv
`timescale 1ns/1ns
module tcsp_status_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire tcsp_pkg::tcsp_mode_t mode,
    input wire logic overcurrent_sensed,
    input wire logic port_power_switch_on,
    input wire logic irq_clear,
    input wire logic cable_mated,
    input wire logic orientation,
    input wire logic overcurrent_alarm_n,
    input wire logic power_switch_irq_source,
    input wire logic vbus_switch_enable,
    input wire logic irq_n
);
    wire logic src = mode == tcsp_pkg::TCSP_MODE_SOURCE;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_oc;
        src && overcurrent_sensed;
    endsequence
    a_alarm_low: assert property (s_oc |=> !overcurrent_alarm_n)
        else $error("alarm not low");
    a_alarm_high: assert property (!src || !overcurrent_sensed
        |=> overcurrent_alarm_n) else $error("alarm low");
    a_irq_source: assert property (s_oc |=> power_switch_irq_source)
        else $error("irq source not set");
    a_switch_on: assert property (src && port_power_switch_on
        && !overcurrent_sensed |=> vbus_switch_enable) else $error("no on");
    a_switch_off: assert property (!port_power_switch_on
        |=> !vbus_switch_enable) else $error("switch on");
    a_irq_low: assert property (power_switch_irq_source |-> !irq_n)
        else $error("irq not low");
    a_irq_hold: assert property (!irq_n && !irq_clear |=> !irq_n)
        else $error("irq dropped");
    a_orient_idle: assert property (!cable_mated |-> !orientation)
        else $error("orientation set");
    a_off_idle: assert property (mode == tcsp_pkg::TCSP_MODE_OFF
        |=> !cable_mated && overcurrent_alarm_n && !vbus_switch_enable)
        else $error("off mode not idle");
    a_event_wins: assert property (src && overcurrent_sensed
        && irq_clear |=> !irq_n) else $error("clear beat event");
endmodule
bind tcsp_status tcsp_status_checker u_chk (.*);

// >>> dv/tcsp_partner.sv
`timescale 1ns/1ns
module tcsp_partner (
    input wire logic plug,
    input wire logic flip,
    input wire logic hub_req,
    output logic cc1_rd_seen,
    output logic cc2_rd_seen,
    output logic cc1_rp_seen,
    output logic cc2_rp_seen,
    output logic cc1_above_cc2,
    output logic port_power_switch_on
);
    assign cc1_rd_seen = plug && !flip;
    assign cc2_rd_seen = plug && flip;
    assign cc1_rp_seen = plug && !flip;
    assign cc2_rp_seen = plug && flip;
    assign cc1_above_cc2 = !flip;
    assign port_power_switch_on = hub_req;
endmodule

// >>> dv/tcsp_status_bench.sv
`timescale 1ns/1ns
module tcsp_status_bench;
    logic core_clk = 0;
    logic rst_n = 0;
    tcsp_pkg::tcsp_mode_t mode = tcsp_pkg::TCSP_MODE_OFF;
    logic oc = 0, hub = 0, clr = 0, plug = 0, flip = 0;
    logic rd1, rd2, rp1, rp2, up, pw, mt, ori, al_n, isrc, sw, irq_n;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    tcsp_partner u_far (.plug(plug), .flip(flip), .hub_req(hub),
        .cc1_rd_seen(rd1), .cc2_rd_seen(rd2), .cc1_rp_seen(rp1),
        .cc2_rp_seen(rp2), .cc1_above_cc2(up), .port_power_switch_on(pw));
    tcsp_status #(.FILTER_CYC(1)) u_dut (.core_clk(core_clk),
        .rst_n(rst_n), .mode(mode), .cc1_rd_seen(rd1), .cc2_rd_seen(rd2),
        .cc1_rp_seen(rp1), .cc2_rp_seen(rp2), .cc1_above_cc2(up),
        .overcurrent_sensed(oc), .port_power_switch_on(pw),
        .irq_clear(clr), .cable_mated(mt), .orientation(ori),
        .overcurrent_alarm_n(al_n), .power_switch_irq_source(isrc),
        .vbus_switch_enable(sw), .irq_n(irq_n));
    task step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task chk(input logic s, input logic e);
        n_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task close_out;
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task t_attach(input tcsp_pkg::tcsp_mode_t m);
        mode = m;
        flip = 0;
        plug = 1;
        step(5);
        chk(mt, 1'h1);
        if (m == tcsp_pkg::TCSP_MODE_SOURCE)
            chk(ori, 1'h0);
        else
            chk(ori, 1'h0);
        plug = 0;
        step(5);
        chk(mt, 1'h0);
        flip = 1;
        plug = 1;
        step(5);
        chk(mt, 1'h1);
        if (m == tcsp_pkg::TCSP_MODE_SOURCE)
            chk(ori, 1'h1);
        else
            chk(ori, 1'h1);
        plug = 0;
        step(5);
        chk(mt, 1'h0);
    endtask
    task t_off;
        mode = tcsp_pkg::TCSP_MODE_OFF;
        plug = 1;
        hub = 1;
        oc = 1;
        step(3);
        chk(mt, 1'h0);
        chk(al_n, 1'h1);
        chk(sw, 1'h0);
        chk(irq_n, 1'h1);
        plug = 0;
        hub = 0;
        oc = 0;
        step(2);
    endtask
    task t_power;
        mode = tcsp_pkg::TCSP_MODE_SOURCE;
        hub = 1;
        step(2);
        chk(sw, 1'h1);
        oc = 1;
        step(1);
        chk(al_n, 1'h0);
        chk(isrc, 1'h1);
        chk(irq_n, 1'h0);
        oc = 0;
        step(1);
        chk(al_n, 1'h1);
        chk(irq_n, 1'h0);
        chk(sw, 1'h1);
        clr = 1;
        step(1);
        chk(irq_n, 1'h1);
        oc = 1;
        step(1);
        oc = 0;
        chk(irq_n, 1'h0);
        step(1);
        clr = 0;
        chk(irq_n, 1'h1);
        hub = 0;
        step(2);
        chk(sw, 1'h0);
        mode = tcsp_pkg::TCSP_MODE_SINK;
        oc = 1;
        step(2);
        chk(al_n, 1'h1);
        oc = 0;
    endtask
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            n_mismatch++;
            close_out;
        end
    end
    initial
    begin
        step(4);
        rst_n = 1;
        step(1);
        t_attach(tcsp_pkg::TCSP_MODE_SOURCE);
        t_attach(tcsp_pkg::TCSP_MODE_SINK);
        t_power;
        t_off;
        close_out;
    end
endmodule
